// [tcc_consts.svh]
// timer16 capture/compare: offsets, field positions, reset values
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_FLAGS 12'h004
`define TCC_OFF_COUNT 12'h008
`define TCC_OFF_IRQEN 12'h00c
`define TCC_OFF_CHCTL0 12'h010
`define TCC_OFF_CMPLO0 12'h020
`define TCC_OFF_CMPHI0 12'h030
`define TCC_OFF_CAPT0 12'h040

// ----------------------------------------
// field positions
// ----------------------------------------
`define TCC_CTRL_MODE_LSB 0
`define TCC_CTRL_DIV_LSB 2
`define TCC_FLG_OVF 3
`define TCC_FLG_COMMON 4
`define TCC_IEN_GLOBAL 0
`define TCC_IEN_OVFM 1
`define TCC_CHC_CAP_LSB 0
`define TCC_CHC_CMPMODE 2
`define TCC_CHC_ACT_LSB 3
`define TCC_CHC_IM 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define TCC_RST_CHCTL 7'h40
`define TCC_RST_IRQEN 2'h0

`endif

// [tcc_pkg.sv]
// timer16 capture/compare: shared types
// assumes nothing beyond the constants header
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_SUSPEND = 2'h0,
        TCC_FREE = 2'h1,
        TCC_MODULO = 2'h2,
        TCC_UPDOWN = 2'h3
    } tcc_mode_t;
    typedef enum logic [2:0] {
        TCC_ACT_SET = 3'h0,
        TCC_ACT_CLR = 3'h1,
        TCC_ACT_TGL = 3'h2,
        TCC_ACT_SET_UP = 3'h3,
        TCC_ACT_CLR_UP = 3'h4,
        TCC_ACT_PWM6 = 3'h5,
        TCC_ACT_PWM7 = 3'h6,
        TCC_ACT_RSV = 3'h7
    } tcc_act_t;
    typedef enum logic [1:0] {
        TCC_CAP_NONE = 2'h0,
        TCC_CAP_RISE = 2'h1,
        TCC_CAP_FALL = 2'h2,
        TCC_CAP_ANY = 2'h3
    } tcc_cap_t;
    typedef enum {
        TCC_DIR_UP,
        TCC_DIR_DOWN
    } tcc_dir_t;
endpackage

// [tcc_timer.sv]
// timer16 capture/compare/pwm with three channels behind an ahb-lite slave
// assumes pin inputs synchronous-capable, one clock, external tick enable
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`include "tcc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int NCH = 3,
    parameter int CW = 16
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // channel pins
    input wire logic [NCH-1:0] ch_pin_i,
    output logic [NCH-1:0] ch_pin_o,
    output logic [NCH-1:0] ch_pin_oe_o,
    // events
    output logic irq_o,
    output logic [NCH-1:0] dma_trigger_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0] mode_r, div_r, irqen_r;
    logic [NCH-1:0] chflag_r, cmp_pend_r, pin_r, dma_r;
    logic [NCH-1:0] sync1_r, sync2_r, sync3_r;
    logic ovf_flag_r, common_flag_r, wr_pend_r;
    logic [6:0] chctl_r [NCH];
    logic [7:0] cmp_lo_buf_r [NCH];
    logic [CW-1:0] cmp_wr_r [NCH], cmp_act_r [NCH], capt_r [NCH];
    logic [CW-1:0] cnt_r;
    logic [6:0] pre_r;
    tcc_dir_t dir_r;
    logic [11:0] waddr_r;

    // ----------------------------------------
    // bus slave: zero wait states, always okay
    // ----------------------------------------
    logic ap_valid, wr_en;
    assign ap_valid = hsel_i && hready_i && htrans_i[1];
    assign wr_en = wr_pend_r && ce_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 12'h000;
        end else if (ce_i) begin
            wr_pend_r <= ap_valid && hwrite_i;
            waddr_r <= haddr_i;
        end
    end

    // channel-indexed register decode
    function automatic logic hit_ch(input logic [11:0] a, input logic [11:0] base, input int ch);
        hit_ch = (a == base + 12'(ch * 4));
    endfunction

    // ----------------------------------------
    // prescaler and counter
    // ----------------------------------------
    logic [6:0] pre_lim;
    logic step, running, at_zero_evt, ovf_evt, cnt_clear;
    logic [CW-1:0] period;
    always_comb begin
        case (div_r)
            2'h0: pre_lim = 7'h00;
            2'h1: pre_lim = 7'h07;
            2'h2: pre_lim = 7'h1f;
            default: pre_lim = 7'h7f;
        endcase
    end
    assign running = (mode_r != TCC_SUSPEND);
    assign step = ce_i && running && tick_i && (pre_r == pre_lim);
    assign period = cmp_act_r[0];
    assign cnt_clear = wr_en && (waddr_r == `TCC_OFF_COUNT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 7'h00;
        end else if (ce_i && running && tick_i) begin
            pre_r <= (pre_r == pre_lim) ? 7'h00 : pre_r + 7'h01;
        end
    end

    logic [CW-1:0] cnt_nxt;
    tcc_dir_t dir_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        ovf_evt = 1'b0;
        at_zero_evt = 1'b0;
        if (step) begin
            case (mode_r)
                TCC_FREE: begin
                    cnt_nxt = cnt_r + 16'h0001;
                    ovf_evt = (cnt_r == 16'hffff);
                end
                TCC_MODULO: begin
                    if (cnt_r >= period) begin
                        cnt_nxt = 16'h0000;
                        ovf_evt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                TCC_UPDOWN: begin
                    if (dir_r == TCC_DIR_UP) begin
                        if (cnt_r >= period) begin
                            dir_nxt = TCC_DIR_DOWN;
                            cnt_nxt = cnt_r - 16'h0001;
                        end else begin
                            cnt_nxt = cnt_r + 16'h0001;
                        end
                    end else if (cnt_r <= 16'h0001) begin
                        cnt_nxt = 16'h0000;
                        dir_nxt = TCC_DIR_UP;
                        ovf_evt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                default: cnt_nxt = cnt_r;
            endcase
            at_zero_evt = (cnt_nxt == 16'h0000);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || cnt_clear) begin
            cnt_r <= 16'h0000;
            dir_r <= TCC_DIR_UP;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
        end
    end

    // ----------------------------------------
    // input synchronisers and edge detect
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else if (ce_i) begin
            sync1_r <= ch_pin_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // ----------------------------------------
    // per-channel events
    // ----------------------------------------
    logic [NCH-1:0] cap_evt, cmp_evt, chflag_set, pin_nxt, ch_req;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic rise, fall, match, cmode;
            tcc_act_t act;
            rise = sync2_r[i] && !sync3_r[i];
            fall = !sync2_r[i] && sync3_r[i];
            cmode = chctl_r[i][`TCC_CHC_CMPMODE];
            act = tcc_act_t'(chctl_r[i][`TCC_CHC_ACT_LSB +: 3]);
            match = step && (cnt_nxt == cmp_act_r[i]);
            cap_evt[i] = 1'b0;
            pin_nxt[i] = pin_r[i];
            if (!cmode && ce_i && running) begin
                case (tcc_cap_t'(chctl_r[i][`TCC_CHC_CAP_LSB +: 2]))
                    TCC_CAP_RISE: cap_evt[i] = rise;
                    TCC_CAP_FALL: cap_evt[i] = fall;
                    TCC_CAP_ANY: cap_evt[i] = rise || fall;
                    default: cap_evt[i] = 1'b0;
                endcase
            end
            cmp_evt[i] = cmode && match;
            ch_pin_oe_o[i] = cmode;
            ch_req[i] = chflag_r[i] && chctl_r[i][`TCC_CHC_IM];
            if (cmode && step) begin
                case (act)
                    TCC_ACT_SET: if (match) pin_nxt[i] = 1'b1;
                    TCC_ACT_CLR: if (match) pin_nxt[i] = 1'b0;
                    TCC_ACT_TGL: if (match) pin_nxt[i] = !pin_r[i];
                    TCC_ACT_SET_UP, TCC_ACT_CLR_UP: begin
                        // set/clear on compare-up, undo at zero or compare-down
                        if (match && dir_nxt == TCC_DIR_UP && cnt_nxt != 16'h0000) begin
                            pin_nxt[i] = (act == TCC_ACT_SET_UP);
                        end else if (at_zero_evt || (match && dir_nxt == TCC_DIR_DOWN)) begin
                            pin_nxt[i] = (act != TCC_ACT_SET_UP);
                        end
                    end
                    TCC_ACT_PWM6, TCC_ACT_PWM7: begin
                        // edge pwm on channels above 0 only
                        if (i != 0) begin
                            if (match) begin
                                pin_nxt[i] = (act == TCC_ACT_PWM7);
                            end else if (at_zero_evt) begin
                                pin_nxt[i] = (act != TCC_ACT_PWM7);
                            end
                        end
                    end
                    default: pin_nxt[i] = pin_r[i];
                endcase
            end
        end
        chflag_set = cap_evt | cmp_evt;
        if (mode_r == TCC_UPDOWN) begin
            chflag_set[0] = at_zero_evt || cap_evt[0];
        end
    end

    // ----------------------------------------
    // pins and dma triggers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_r <= '0;
            dma_r <= '0;
        end else if (ce_i) begin
            pin_r <= pin_nxt;
            dma_r <= cmp_evt;
        end else begin
            dma_r <= '0;
        end
    end
    assign ch_pin_o = pin_r;
    assign dma_trigger_o = dma_r;

    // ----------------------------------------
    // capture and compare registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_pend_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                cmp_lo_buf_r[i] <= 8'h00;
                cmp_wr_r[i] <= 16'h0000;
                cmp_act_r[i] <= 16'h0000;
                capt_r[i] <= 16'h0000;
            end
        end else if (ce_i) begin
            for (int i = 0; i < NCH; i++) begin
                logic imm;
                imm = (chctl_r[i][`TCC_CHC_ACT_LSB +: 3] <= 3'h2);
                if (cap_evt[i]) capt_r[i] <= cnt_r;
                if (wr_en && hit_ch(waddr_r, `TCC_OFF_CMPLO0, i)) begin
                    cmp_lo_buf_r[i] <= hwdata_i[7:0];
                end
                if (wr_en && hit_ch(waddr_r, `TCC_OFF_CMPHI0, i)) begin
                    cmp_wr_r[i] <= {hwdata_i[7:0], cmp_lo_buf_r[i]};
                    if (imm) begin
                        cmp_act_r[i] <= {hwdata_i[7:0], cmp_lo_buf_r[i]};
                        cmp_pend_r[i] <= 1'b0;
                    end else begin
                        cmp_pend_r[i] <= 1'b1;
                    end
                end else if (cmp_pend_r[i] && (cnt_r == 16'h0000)) begin
                    cmp_act_r[i] <= cmp_wr_r[i];
                    cmp_pend_r[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= 2'h0;
            div_r <= 2'h0;
            irqen_r <= `TCC_RST_IRQEN;
            for (int i = 0; i < NCH; i++) begin
                chctl_r[i] <= `TCC_RST_CHCTL;
            end
        end else if (wr_en) begin
            if (waddr_r == `TCC_OFF_CTRL) begin
                mode_r <= hwdata_i[`TCC_CTRL_MODE_LSB +: 2];
                div_r <= hwdata_i[`TCC_CTRL_DIV_LSB +: 2];
            end
            if (waddr_r == `TCC_OFF_IRQEN) irqen_r <= hwdata_i[1:0];
            for (int i = 0; i < NCH; i++) begin
                if (hit_ch(waddr_r, `TCC_OFF_CHCTL0, i)) begin
                    chctl_r[i] <= hwdata_i[6:0];
                end
            end
        end
    end

    // ----------------------------------------
    // flags: set wins over write-zero clear
    // ----------------------------------------
    logic flag_wr;
    assign flag_wr = wr_en && (waddr_r == `TCC_OFF_FLAGS);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chflag_r <= '0;
            ovf_flag_r <= 1'b0;
            common_flag_r <= 1'b0;
        end else if (ce_i) begin
            for (int i = 0; i < NCH; i++) begin
                if (chflag_set[i]) begin
                    chflag_r[i] <= 1'b1;
                end else if (flag_wr && !hwdata_i[i]) begin
                    chflag_r[i] <= 1'b0;
                end
            end
            if (ovf_evt) begin
                ovf_flag_r <= 1'b1;
            end else if (flag_wr && !hwdata_i[`TCC_FLG_OVF]) begin
                ovf_flag_r <= 1'b0;
            end
            if (ovf_evt || (|chflag_set)) begin
                common_flag_r <= 1'b1;
            end else if (flag_wr && !hwdata_i[`TCC_FLG_COMMON]) begin
                common_flag_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // single interrupt request, level from flags and masks
    // ----------------------------------------
    // level request follows flag and mask at once
    assign irq_o = irqen_r[`TCC_IEN_GLOBAL]
        && ((ovf_flag_r && irqen_r[`TCC_IEN_OVFM]) || (|ch_req));

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (ce_i && ap_valid && !hwrite_i) begin
            hrdata_o <= 32'h00000000;
            if (haddr_i == `TCC_OFF_CTRL) hrdata_o <= {28'h0000000, div_r, mode_r};
            if (haddr_i == `TCC_OFF_FLAGS) begin
                hrdata_o <= {27'h0000000, common_flag_r, ovf_flag_r, chflag_r};
            end
            if (haddr_i == `TCC_OFF_COUNT) hrdata_o <= {16'h0000, cnt_r};
            if (haddr_i == `TCC_OFF_IRQEN) hrdata_o <= {30'h00000000, irqen_r};
            for (int i = 0; i < NCH; i++) begin
                if (hit_ch(haddr_i, `TCC_OFF_CHCTL0, i)) hrdata_o <= {25'h0000000, chctl_r[i]};
                if (hit_ch(haddr_i, `TCC_OFF_CMPLO0, i)) hrdata_o <= {24'h000000, cmp_lo_buf_r[i]};
                if (hit_ch(haddr_i, `TCC_OFF_CMPHI0, i)) hrdata_o <= {16'h0000, cmp_act_r[i]};
                if (hit_ch(haddr_i, `TCC_OFF_CAPT0, i)) hrdata_o <= {16'h0000, capt_r[i]};
            end
        end
    end
endmodule
`default_nettype wire

// [tcc_timer_chk.sv]
// assertions on the timer ports, with a shadow of the written control bits
// assumes word writes over ahb-lite and a bind from the bench
`include "tcc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_chk #(
    parameter int NCH = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // bus
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    // pins and events
    input wire logic [NCH-1:0] ch_pin_o,
    input wire logic [NCH-1:0] ch_pin_oe_o,
    input wire logic irq_o,
    input wire logic [NCH-1:0] dma_trigger_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take_w;
    logic wr_r;
    logic [11:0] ad_r;
    logic glob_r;
    logic [1:0] mode_r;
    logic [NCH-1:0] oe_r;
    assign take_w = hsel_i && hready_i && htrans_i[1] && ce_i;
    always_ff @(posedge clk_i) begin
        wr_r <= !rst_i && take_w && hwrite_i;
        ad_r <= haddr_i;
    end
    // ----------------------------------------
    // shadow of global enable, mode, compare select
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            glob_r <= 1'b0;
            mode_r <= 2'h0;
            oe_r <= '0;
        end else if (wr_r && ce_i) begin
            if (ad_r == `TCC_OFF_IRQEN) glob_r <= hwdata_i[`TCC_IEN_GLOBAL];
            if (ad_r == `TCC_OFF_CTRL) mode_r <= hwdata_i[1:0];
            for (int k = 0; k < NCH; k++) begin
                if (ad_r == `TCC_OFF_CHCTL0 + 12'(4 * k)) oe_r[k] <= hwdata_i[2];
            end
        end
    end
    a_rdata_hold: assert property (!(take_w && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_irq_global: assert property (!glob_r |-> !irq_o)
        else $error("request without global enable");
    a_pin_dir: assert property (ch_pin_oe_o == oe_r)
        else $error("pin direction differs from channel mode");
    a_dma_pulse: assert property ($past(dma_trigger_o) != '0 |->
        (dma_trigger_o & $past(dma_trigger_o)) == '0)
        else $error("dma trigger longer than one cycle");
    a_dma_cmp: assert property ((dma_trigger_o & ~ch_pin_oe_o) == '0)
        else $error("dma trigger on a capture channel");
    a_ce_quiet: assert property (!ce_i |=> dma_trigger_o == '0)
        else $error("dma trigger while frozen");
    a_idle_quiet: assert property (mode_r == 2'h0 && $past(mode_r) == 2'h0 |-> dma_trigger_o == '0)
        else $error("event while suspended");
    a_pin_clean: assert property ($changed(ch_pin_o) |=>
        ((ch_pin_o ^ $past(ch_pin_o)) & ($past(ch_pin_o) ^ $past(ch_pin_o, 2))) == '0)
        else $error("compare pin moved twice in a row");
    c_irq: cover property (irq_o);
    c_dma: cover property (dma_trigger_o[NCH-1]);
    c_pin: cover property ($rose(ch_pin_o[NCH-1]));
endmodule
`default_nettype wire

// [tcc_pin_src.sv]
// far side of the channel pins: event source and load
// assumes one-cycle requests from the bench on its clock
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_src (
    // clock
    input wire logic clk_i,
    // requests
    input wire logic [2:0] req_i,
    input wire logic [2:0] width_i,
    // pin wires
    input wire logic [2:0] dut_pin_i,
    input wire logic [2:0] dut_oe_i,
    output logic [2:0] pin_o
);
    logic [2:0] lvl_r = '0;
    logic [2:0][2:0] cnt_r = '0;
    // pulse lasts width_i clocks, never under two
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            if (req_i[k]) begin
                lvl_r[k] <= 1'b1;
                cnt_r[k] <= (width_i < 3'h2) ? 3'h2 : width_i;
            end else if (cnt_r[k] > 3'h1) begin
                cnt_r[k] <= cnt_r[k] - 3'h1;
            end else begin
                lvl_r[k] <= 1'b0;
            end
        end
    end
    // a compare channel drives the wire, the source stays off it
    assign pin_o = (dut_oe_i & dut_pin_i) | (~dut_oe_i & lvl_r);
endmodule
`default_nettype wire

// [tcc_timer_bench.sv]
// self-checking bench for the timer, with the pin source on the far side
// assumes 50 mhz clock and a tick every clock unless randomised
`include "tcc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_bench;
    typedef struct packed {
        logic [31:0] v;
        logic [31:0] m;
        logic le;
    } tcc_note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic tick_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [11:0] haddr_i = '0;
    logic [1:0] htrans_i = '0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = '0;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [2:0] ch_pin_i;
    logic [2:0] ch_pin_o;
    logic [2:0] ch_pin_oe_o;
    logic irq_o;
    logic [2:0] dma_trigger_o;
    logic [2:0] req = '0;
    logic [2:0] width = 3'h2;
    logic rd_dp = 1'b0;
    logic pin_prev = 1'b0;
    logic [31:0] seed = 32'hc484;
    int miscompares = 0;
    int n_checks = 0;
    int n_dma = 0;
    int n_tgl = 0;
    int s1;
    int s2;
    tcc_note_t notes[$];
    tcc_note_t cur;
    always #10 clk_i = ~clk_i;
    tcc_timer u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tick_i(tick_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ch_pin_i(ch_pin_i),
        .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o), .irq_o(irq_o),
        .dma_trigger_o(dma_trigger_o)
    );
    tcc_pin_src u_src (
        .clk_i(clk_i), .req_i(req), .width_i(width), .dut_pin_i(ch_pin_o),
        .dut_oe_i(ch_pin_oe_o), .pin_o(ch_pin_i)
    );
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                tally_and_finish();
            end
            @(posedge clk_i);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input tcc_note_t nt);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= w;
        wait_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        if (!w) notes.push_back(nt);
        rd_dp <= !w;
        wait_rdy();
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, '0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
        bus(1'b0, a, '0, {v, m, 1'b0});
    endtask
    task automatic rle(input logic [11:0] a, input logic [31:0] v);
        bus(1'b0, a, '0, {v, 32'hffff, 1'b1});
    endtask
    task automatic irq_is(input logic e);
        @(negedge clk_i);
        check({31'h0, irq_o}, {31'h0, e});
        @(posedge clk_i);
    endtask
    // read data is taken at the data-phase edge against the oldest note
    always @(posedge clk_i) begin
        if (rd_dp && hreadyout_o) begin
            cur = notes.pop_front();
            check({31'h0, hresp_o}, 32'h0);
            if (cur.le) check({31'h0, (hrdata_o & cur.m) <= cur.v}, 32'h1);
            else check(hrdata_o & cur.m, cur.v);
        end
    end
    always @(negedge clk_i) begin
        if (dma_trigger_o[2] === 1'b1) n_dma++;
        if (ch_pin_o[2] !== pin_prev) n_tgl++;
        pin_prev = ch_pin_o[2];
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TCC_OFF_CTRL, 32'h0, 32'h3);
        rd(`TCC_OFF_CHCTL0 + 12'h4, {25'h0, `TCC_RST_CHCTL}, 32'h7f);
        rd(12'hffc, 32'h0, 32'hffffffff);
        wr(`TCC_OFF_CMPLO0, 32'h5);
        wr(`TCC_OFF_CMPHI0, 32'h0);
        rd(`TCC_OFF_CMPHI0, 32'h5, 32'hffff);
        wr(`TCC_OFF_CMPLO0 + 12'h8, 32'h3);
        wr(`TCC_OFF_CMPHI0 + 12'h8, 32'h0);
        wr(`TCC_OFF_CHCTL0 + 12'h8, 32'h54);
        wr(`TCC_OFF_CTRL, 32'h2);
        repeat (12) rle(`TCC_OFF_COUNT, 32'h5);
        s1 = n_dma;
        s2 = n_tgl;
        repeat (60) @(posedge clk_i);
        check(32'(n_dma - s1), 32'd10);
        check(32'(n_tgl - s2), 32'd10);
        ce_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        ce_i <= 1'b1;
        seed = xs(seed);
        wr(`TCC_OFF_CMPLO0 + 12'h8, {24'h0, seed[7:0]});
        rd(`TCC_OFF_CMPHI0 + 12'h8, 32'h3, 32'hffff);
        rd(`TCC_OFF_CMPLO0 + 12'h8, {24'h0, seed[7:0]}, 32'hff);
        wr(`TCC_OFF_CMPHI0 + 12'h8, 32'h0);
        rd(`TCC_OFF_CMPHI0 + 12'h8, {24'h0, seed[7:0]}, 32'hffff);
        wr(`TCC_OFF_CTRL, 32'h0);
        rd(`TCC_OFF_FLAGS, 32'h1c, 32'h1f);
        wr(`TCC_OFF_FLAGS, 32'h1b);
        rd(`TCC_OFF_FLAGS, 32'h18, 32'h1f);
        irq_is(1'b0);
        wr(`TCC_OFF_IRQEN, 32'h2);
        irq_is(1'b0);
        wr(`TCC_OFF_IRQEN, 32'h3);
        irq_is(1'b1);
        wr(`TCC_OFF_FLAGS, 32'h0);
        irq_is(1'b0);
        repeat (30) @(posedge clk_i);
        rd(`TCC_OFF_FLAGS, 32'h0, 32'h1f);
        wr(`TCC_OFF_CHCTL0 + 12'h8, 32'h14);
        wr(`TCC_OFF_CHCTL0 + 12'h4, 32'h41);
        wr(`TCC_OFF_IRQEN, 32'h1);
        wr(`TCC_OFF_CTRL, 32'h2);
        wr(`TCC_OFF_FLAGS, 32'h0);
        irq_is(1'b0);
        seed = xs(seed);
        width <= 3'h2 + {1'b0, seed[1:0]};
        req <= 3'h2;
        @(posedge clk_i);
        req <= 3'h0;
        repeat (10) @(posedge clk_i);
        irq_is(1'b1);
        rd(`TCC_OFF_FLAGS, 32'h12, 32'h13);
        rle(`TCC_OFF_CAPT0 + 12'h4, 32'h5);
        wr(`TCC_OFF_CTRL, 32'h3);
        repeat (40) begin
            @(posedge clk_i);
            seed = xs(seed);
            tick_i <= seed[0];
        end
        tick_i <= 1'b1;
        repeat (10) rle(`TCC_OFF_COUNT, 32'h5);
        wr(`TCC_OFF_FLAGS, 32'h0);
        repeat (20) @(posedge clk_i);
        rd(`TCC_OFF_FLAGS, 32'h18, 32'h18);
        wr(`TCC_OFF_CHCTL0 + 12'h4, 32'h5c);
        wr(`TCC_OFF_CMPLO0 + 12'h4, 32'h2);
        wr(`TCC_OFF_CMPHI0 + 12'h4, 32'h0);
        rd(`TCC_OFF_CMPHI0 + 12'h4, 32'h0, 32'hffff);
        repeat (20) @(posedge clk_i);
        rd(`TCC_OFF_CMPHI0 + 12'h4, 32'h2, 32'hffff);
        tally_and_finish();
    end
endmodule
bind tcc_timer tcc_timer_chk #(.NCH(NCH)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o), .irq_o(irq_o),
    .dma_trigger_o(dma_trigger_o)
);
`default_nettype wire
